// ==== core/motor_speed_consts.svh ====
`ifndef MOTOR_SPEED_CONSTS_SVH
`define MOTOR_SPEED_CONSTS_SVH

`define REG_RAMP_OFS        4'h0
`define REG_PI_OFS          4'h4
`define REG_CTRL_OFS        4'h8
`define REG_STATUS_OFS      4'hc

`define CTRL_MASK_EN_BIT    0
`define CTRL_REL_SEL_BIT    1
`define CTRL_TONE_EN_BIT    2
`define CTRL_HOLD_DUR_LSB   3
`define CTRL_THREE_PER_BIT  5
`define CTRL_OV_MUTE_BIT    6

`define RST_STEP_INTERVAL   8'h10
`define RST_EXIT_THRESHOLD  6'h04
`define RST_ERROR_CLAMP     8'hff
`define RST_PROP_GAIN       8'h18
`define RST_INT_GAIN        8'h03
`define RST_CTRL            7'h21

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`define CLK_PERIOD_NS       40
`define MS_TICK_NS          1000000
`define MS_TICK_CYC         (`MS_TICK_NS / `CLK_PERIOD_NS)
`define RAMP_UNIT_NS        819000
`define RAMP_UNIT_CYC       (`RAMP_UNIT_NS / `CLK_PERIOD_NS)

`define DUTY_MAX            10'h3ff
`define DIV_STEPS           4'ha
`define EXIT_THR_SHIFT      2
`define CLAMP_FULL_CODE     8'h80
`define CLAMP_SHIFT         3
`define CLAMP_FULL          11'h400
`define P_GAIN_SHIFT        6
`define I_FRAC_BITS         8

`define PROT_TIME_MS        14'h1388
`define LOCK_TIME_MS        14'h03e8
`define FREQ_BAD_MS         14'h0096
`define FREQ_GOOD_CYCLES    4'hf
`define RELEASE_COUNT_A     4'h5
`define RELEASE_COUNT_B     4'h9
`define HOLD_HALF_PERIODS   3'h5
`define HOLD_0_MS           14'h0bb8
`define HOLD_1_MS           14'h1388
`define HOLD_2_MS           14'h1b58
`define HOLD_3_MS           14'h36b0
`define TONE_HALF_1HZ_MS    14'h01f4
`define TONE_HALF_2HZ_MS    14'h00fa
`define TONE_HALF_3HZ_MS    14'h00a6
`define TONE_HALF_4HZ_MS    14'h007d
`define TONE_HALF_5HZ_MS    14'h0064

`define TONE_NONE           3'h0
`define TONE_LOW            3'h7

`endif

// ==== core/motor_speed_pkg.sv ====
package motor_speed_pkg;
	typedef enum logic [1:0] {
		MODE_RAMP = 2'b01,
		MODE_PI   = 2'b10
	} ctrl_mode_t;
	typedef logic [9:0] duty_t;
	typedef logic [2:0] tone_code_t;
endpackage : motor_speed_pkg

// ==== core/motor_speed_loop.sv ====
// Behaviour
// - Speed error is target minus measured half period; slow motor gives negative error.
// - Ramp stepping during startup and speed changes, PI regulation in steady running.
// - Ramp raises duty one step on negative error, lowers on positive error.
// - Ramp step spacing is setting plus one times 0.819 ms, separate accel/decel.
// - Switch to PI once error magnitude is within threshold times 0.391 percent.
// - Clamp error to setting times 0.781 percent; above 128 means no clamp.
// - Proportional gain is setting times 0.01564.
// - Integral gain is setting times 0.00391.
// - With mask enabled, rotation pulses are suppressed through startup until stable.
// - Mask releases after 5 or 9 stable detections; output from the next one.
// - Sudden acceleration or stall breaks the consecutive stable detection count.
// - Enabled fault tone replaces rotation pulses during detection and protection time.
// - After last fault, tone lasts three periods or the selected minimum duration.
// - Minimum tone duration is 3, 5, 7 or 14 s by code.
// - Seven self-clearing protections force FETs off, ranked by fixed priority.
// - Tone is 1 to 5 Hz per fault; supply undervoltage drives low.
// - Overcurrent releases only after protection time and with sense below threshold.
// - Stall on missing edges, overspeed or underspeed; release after protection time.
// - Input frequency fault after 150 ms bad; clears after 15 good cycles.
// - Boost undervoltage holds the current tone frequency.
// - Overvoltage boost mute persists until the overvoltage protection releases.
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "motor_speed_consts.svh"
module motor_speed_loop
	import motor_speed_pkg::*;
#(
	parameter int MS_TICK_CYC   = `MS_TICK_CYC,
	parameter int RAMP_UNIT_CYC = `RAMP_UNIT_CYC
) (
	input  wire logic        SYS_CLK,
	input  wire logic        ARST_N,
	input  wire logic [3:0]  AWADDR,
	input  wire logic        AWVALID,
	output var  logic        AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output var  logic        WREADY,
	output var  logic [1:0]  BRESP,
	output var  logic        BVALID,
	input  wire logic        BREADY,
	input  wire logic [3:0]  ARADDR,
	input  wire logic        ARVALID,
	output var  logic        ARREADY,
	output var  logic [31:0] RDATA,
	output var  logic [1:0]  RRESP,
	output var  logic        RVALID,
	input  wire logic        RREADY,
	input  wire logic [15:0] MEAS_HALF_PERIOD,
	input  wire logic        MEAS_VALID,
	input  wire logic [15:0] TARGET_HALF_PERIOD,
	input  wire logic        DRIVE_ON,
	input  wire logic        INT_PULSE,
	input  wire logic        STARTUP_SYNC,
	input  wire logic        BEMF_DETECT,
	input  wire logic        BEMF_STABLE,
	input  wire logic        BEMF_EDGE,
	input  wire logic        SUDDEN_ACCEL,
	input  wire logic        OVERSPEED_DETECT,
	input  wire logic        UNDERSPEED_DETECT,
	input  wire logic        SPEED_COMMAND_BAD,
	input  wire logic        SPEED_COMMAND_CYCLE,
	input  wire logic        SUPPLY_UNDERVOLTAGE,
	input  wire logic        BOOST_UNDERVOLTAGE,
	input  wire logic        OVERCURRENT_SENSE_INPUT,
	input  wire logic        THERMAL_HOT,
	input  wire logic        OVERVOLTAGE,
	output var  logic [9:0]  DUTY,
	output var  logic        FET_OFF,
	output var  logic        BOOST_MUTE,
	output var  logic        ROTATION_PULSE_OUTPUT
);
	logic [7:0]  accel_step_interval, decel_step_interval, speed_error_clamp;
	logic [7:0]  proportional_gain, integral_gain;
	logic [5:0]  ramp_exit_threshold;
	logic [6:0]  ctrl;
	logic [3:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;
	logic [4:0]  pin_meta, pin_sync;
	logic [6:0]  active;
	logic [13:0] prot_ms [2:5];
	logic [14:0] tick_cnt;
	logic        ms_tick;
	ctrl_mode_t  mode;
	duty_t       duty;
	logic [15:0] last_target;
	logic        div_busy, err_valid, err_neg, div_neg;
	logic [3:0]  div_cnt;
	logic [16:0] rem;
	logic [9:0]  quo, err_mag;
	logic [10:0] clamp_lim, err_c;
	logic signed [11:0] err_s;
	logic signed [21:0] p_term;
	logic signed [21:0] integ, next_integ;
	logic signed [22:0] next_sum;
	logic [14:0] ramp_unit_cnt;
	logic [7:0]  ramp_units, step_limit;
	logic [13:0] lock_ms, freq_ms;
	logic [3:0]  good_cycles, stable_cnt;
	logic        stall_trig, mask_on;
	logic [5:2]  trig;
	tone_code_t  tone_code, next_tone;
	logic [13:0] half_ms, half_len, hold_ms, hold_len;
	logic [2:0]  hold_halves;
	logic        tone_level, half_done;

	// The bus takes address and data in either order and answers after both.
	assign do_write = !AWREADY && !WREADY && !BVALID;
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			AWREADY <= 1'b1;
			WREADY  <= 1'b1;
			BVALID  <= 1'b0;
			BRESP   <= `RESP_OKAY;
			aw_addr <= 4'h0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
		end else begin
			if (AWVALID && AWREADY) begin
				AWREADY <= 1'b0;
				aw_addr <= AWADDR;
			end
			if (WVALID && WREADY) begin
				WREADY <= 1'b0;
				w_data <= WDATA;
				w_strb <= WSTRB;
			end
			if (do_write) begin
				BVALID <= 1'b1;
				BRESP  <= (aw_addr == `REG_RAMP_OFS || aw_addr == `REG_PI_OFS ||
					aw_addr == `REG_CTRL_OFS) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (BVALID && BREADY) begin
				BVALID  <= 1'b0;
				AWREADY <= 1'b1;
				WREADY  <= 1'b1;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			accel_step_interval <= `RST_STEP_INTERVAL;
			decel_step_interval <= `RST_STEP_INTERVAL;
			ramp_exit_threshold <= `RST_EXIT_THRESHOLD;
			speed_error_clamp   <= `RST_ERROR_CLAMP;
			proportional_gain   <= `RST_PROP_GAIN;
			integral_gain       <= `RST_INT_GAIN;
			ctrl                <= `RST_CTRL;
		end else if (do_write) begin
			if (aw_addr == `REG_RAMP_OFS) begin
				if (w_strb[0]) accel_step_interval <= w_data[7:0];
				if (w_strb[1]) decel_step_interval <= w_data[15:8];
				if (w_strb[2]) ramp_exit_threshold <= w_data[21:16];
			end
			if (aw_addr == `REG_PI_OFS) begin
				if (w_strb[0]) speed_error_clamp <= w_data[7:0];
				if (w_strb[1]) proportional_gain <= w_data[15:8];
				if (w_strb[2]) integral_gain     <= w_data[23:16];
			end
			if (aw_addr == `REG_CTRL_OFS && w_strb[0]) ctrl <= w_data[6:0];
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ARREADY <= 1'b1;
			RVALID  <= 1'b0;
			RDATA   <= 32'h0;
			RRESP   <= `RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b1;
			RRESP   <= `RESP_OKAY;
			unique case (ARADDR)
				`REG_RAMP_OFS: RDATA <= {10'h0, ramp_exit_threshold, decel_step_interval,
					accel_step_interval};
				`REG_PI_OFS: RDATA <= {8'h0, integral_gain, proportional_gain,
					speed_error_clamp};
				`REG_CTRL_OFS: RDATA <= {25'h0, ctrl};
				`REG_STATUS_OFS: RDATA <= {10'h0, tone_code, active, mask_on,
					mode == MODE_PI, duty};
				default: begin
					RDATA <= 32'h0;
					RRESP <= `RESP_SLVERR;
				end
			endcase
		end else if (RVALID && RREADY) begin
			RVALID  <= 1'b0;
			ARREADY <= 1'b1;
		end
	end

	// Analog comparator levels arrive unsynchronised.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pin_meta <= 5'h0;
			pin_sync <= 5'h0;
		end else begin
			pin_meta <= {OVERVOLTAGE, THERMAL_HOT, OVERCURRENT_SENSE_INPUT,
				BOOST_UNDERVOLTAGE, SUPPLY_UNDERVOLTAGE};
			pin_sync <= pin_meta;
		end
	end

	assign ms_tick = (tick_cnt == 15'(MS_TICK_CYC - 1));
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) tick_cnt <= 15'h0;
		else tick_cnt <= ms_tick ? 15'h0 : tick_cnt + 15'h1;
	end

	// Restoring division gives the error as a fraction of target in 1/1024 units.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			div_busy  <= 1'b0;
			div_cnt   <= 4'h0;
			div_neg   <= 1'b0;
			rem       <= 17'h0;
			quo       <= 10'h0;
			err_valid <= 1'b0;
			err_neg   <= 1'b0;
			err_mag   <= 10'h0;
		end else begin
			err_valid <= 1'b0;
			if (!div_busy && MEAS_VALID) begin
				div_neg <= MEAS_HALF_PERIOD > TARGET_HALF_PERIOD;
				rem     <= (MEAS_HALF_PERIOD > TARGET_HALF_PERIOD) ?
					{1'b0, MEAS_HALF_PERIOD - TARGET_HALF_PERIOD} :
					{1'b0, TARGET_HALF_PERIOD - MEAS_HALF_PERIOD};
				quo      <= 10'h0;
				div_cnt  <= `DIV_STEPS;
				div_busy <= 1'b1;
			end else if (div_busy) begin
				if ({rem[15:0], 1'b0} >= {1'b0, TARGET_HALF_PERIOD}) begin
					rem <= {rem[15:0], 1'b0} - {1'b0, TARGET_HALF_PERIOD};
					quo <= {quo[8:0], 1'b1};
				end else begin
					rem <= {rem[15:0], 1'b0};
					quo <= {quo[8:0], 1'b0};
				end
				if (div_cnt == 4'h1) begin
					div_busy  <= 1'b0;
					err_valid <= 1'b1;
				end
				div_cnt <= div_cnt - 4'h1;
			end
			if (!div_busy && MEAS_VALID && (TARGET_HALF_PERIOD == 16'h0 ||
				(MEAS_HALF_PERIOD > TARGET_HALF_PERIOD &&
				MEAS_HALF_PERIOD - TARGET_HALF_PERIOD >= TARGET_HALF_PERIOD))) begin
				err_mag <= `DUTY_MAX;
				quo     <= `DUTY_MAX;
			end
			if (div_busy && div_cnt == 4'h1) begin
				err_neg <= div_neg;
				err_mag <= (err_mag == `DUTY_MAX && quo == `DUTY_MAX) ? `DUTY_MAX :
					{quo[8:0], {rem[15:0], 1'b0} >= {1'b0, TARGET_HALF_PERIOD}};
			end
		end
	end

	always_comb begin
		clamp_lim = (speed_error_clamp > `CLAMP_FULL_CODE) ? `CLAMP_FULL :
			{speed_error_clamp, 3'h0};
		err_c = ({1'b0, err_mag} > clamp_lim) ? clamp_lim : {1'b0, err_mag};
		err_s = err_neg ? -$signed({1'b0, err_c}) : $signed({1'b0, err_c});
		p_term = (22'(err_s) * $signed({14'h0, proportional_gain})) >>>
			`P_GAIN_SHIFT;
		next_integ = integ + 22'(err_s) * $signed({14'h0, integral_gain});
		if (next_integ < 0) next_integ = 22'sh0;
		if (next_integ > $signed({4'h0, `DUTY_MAX, 8'h0})) begin
			next_integ = $signed({4'h0, `DUTY_MAX, 8'h0});
		end
		next_sum = 23'(next_integ >>> `I_FRAC_BITS) + 23'(p_term);
	end

	// Leaving PI on a new target lets ramp stepping take the speed change.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mode        <= MODE_RAMP;
			duty        <= 10'h0;
			integ       <= 22'sh0;
			last_target <= 16'h0;
		end else begin
			last_target <= TARGET_HALF_PERIOD;
			unique case (mode)
				MODE_RAMP: begin
					if (err_valid && err_mag <= {2'h0, ramp_exit_threshold,
						2'h0}) begin
						mode  <= MODE_PI;
						integ <= $signed({4'h0, duty, 8'h0});
					end else if (ramp_units == step_limit &&
						ramp_unit_cnt == 15'(RAMP_UNIT_CYC - 1) && err_mag != 10'h0) begin
						if (err_neg && duty != `DUTY_MAX) duty <= duty + 10'h1;
						if (!err_neg && duty != 10'h0) duty <= duty - 10'h1;
					end
				end
				MODE_PI: begin
					if (last_target != TARGET_HALF_PERIOD) mode <= MODE_RAMP;
					else if (err_valid) begin
						integ <= next_integ;
						duty  <= (next_sum < 0) ? 10'h0 :
							(next_sum > 23'sd1023) ? `DUTY_MAX : next_sum[9:0];
					end
				end
			endcase
			if (active != 7'h0) begin
				mode  <= MODE_RAMP;
				duty  <= 10'h0;
				integ <= 22'sh0;
			end
		end
	end

	assign step_limit = err_neg ? accel_step_interval : decel_step_interval;
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ramp_unit_cnt <= 15'h0;
			ramp_units    <= 8'h0;
		end else if (mode != MODE_RAMP) begin
			ramp_unit_cnt <= 15'h0;
			ramp_units    <= 8'h0;
		end else if (ramp_unit_cnt == 15'(RAMP_UNIT_CYC - 1)) begin
			ramp_unit_cnt <= 15'h0;
			ramp_units    <= (ramp_units >= step_limit) ? 8'h0 : ramp_units + 8'h1;
		end else begin
			ramp_unit_cnt <= ramp_unit_cnt + 15'h1;
		end
	end

	// Undervoltage follows its comparator; overcurrent, thermal, overvoltage and stall hold for the protection time.
	assign stall_trig = OVERSPEED_DETECT || UNDERSPEED_DETECT || lock_ms == `LOCK_TIME_MS;
	assign trig = {stall_trig, pin_sync[4:2]};
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			active  <= 7'h0;
			lock_ms <= 14'h0;
			for (int i = 2; i <= 5; i++) prot_ms[i] <= 14'h0;
		end else begin
			active[1:0] <= pin_sync[1:0];
			for (int i = 2; i <= 5; i++) begin
				if (!active[i] && trig[i]) begin
					active[i]  <= 1'b1;
					prot_ms[i] <= 14'h0;
				end else if (active[i] && prot_ms[i] != `PROT_TIME_MS) begin
					prot_ms[i] <= prot_ms[i] + {13'h0, ms_tick};
				end else if (active[i] && (i == 5 || !trig[i])) begin
					active[i] <= 1'b0;
				end
			end
			if (!DRIVE_ON || BEMF_EDGE || active[5]) lock_ms <= 14'h0;
			else if (lock_ms != `LOCK_TIME_MS) lock_ms <= lock_ms + {13'h0, ms_tick};
			active[6] <= (freq_ms == `FREQ_BAD_MS) ? 1'b1 :
				(good_cycles == `FREQ_GOOD_CYCLES) ? 1'b0 : active[6];
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			freq_ms     <= 14'h0;
			good_cycles <= 4'h0;
		end else begin
			if (!SPEED_COMMAND_BAD) freq_ms <= 14'h0;
			else if (freq_ms != `FREQ_BAD_MS) freq_ms <= freq_ms + {13'h0, ms_tick};
			if (SPEED_COMMAND_BAD || !active[6]) good_cycles <= 4'h0;
			else if (SPEED_COMMAND_CYCLE) good_cycles <= good_cycles + 4'h1;
		end
	end

	// Any stall or sudden acceleration restarts the stable count.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mask_on    <= 1'b1;
			stable_cnt <= 4'h0;
		end else if (!ctrl[`CTRL_MASK_EN_BIT]) begin
			mask_on    <= 1'b0;
			stable_cnt <= 4'h0;
		end else if (STARTUP_SYNC) begin
			mask_on    <= 1'b1;
			stable_cnt <= 4'h0;
		end else if (SUDDEN_ACCEL || stall_trig || active[5]) begin
			stable_cnt <= 4'h0;
		end else if (mask_on && BEMF_DETECT) begin
			if (!BEMF_STABLE) stable_cnt <= 4'h0;
			else if (stable_cnt == (ctrl[`CTRL_REL_SEL_BIT] ? `RELEASE_COUNT_B :
				`RELEASE_COUNT_A)) mask_on <= 1'b0;
			else stable_cnt <= stable_cnt + 4'h1;
		end
	end

	always_comb begin
		if (active[0]) next_tone = `TONE_LOW;
		else if (active[1]) next_tone = tone_code;
		else if (active[2]) next_tone = 3'h1;
		else if (active[3]) next_tone = 3'h2;
		else if (active[4]) next_tone = 3'h3;
		else if (active[5]) next_tone = 3'h4;
		else if (active[6]) next_tone = 3'h5;
		else next_tone = `TONE_NONE;
		unique case (tone_code)
			3'h1: half_len = `TONE_HALF_1HZ_MS;
			3'h2: half_len = `TONE_HALF_2HZ_MS;
			3'h3: half_len = `TONE_HALF_3HZ_MS;
			3'h4: half_len = `TONE_HALF_4HZ_MS;
			default: half_len = `TONE_HALF_5HZ_MS;
		endcase
		unique case (ctrl[`CTRL_HOLD_DUR_LSB +: 2])
			2'h0: hold_len = `HOLD_0_MS;
			2'h1: hold_len = `HOLD_1_MS;
			2'h2: hold_len = `HOLD_2_MS;
			default: hold_len = `HOLD_3_MS;
		endcase
	end

	assign half_done = ms_tick && half_ms == half_len - 14'h1;
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tone_code   <= `TONE_NONE;
			hold_ms     <= 14'h0;
			hold_halves <= 3'h0;
		end else if (!ctrl[`CTRL_TONE_EN_BIT]) begin
			tone_code   <= `TONE_NONE;
			hold_ms     <= 14'h0;
			hold_halves <= 3'h0;
		end else if (next_tone != `TONE_NONE) begin
			tone_code   <= next_tone;
			hold_ms     <= 14'h0;
			hold_halves <= 3'h0;
		end else if (tone_code == `TONE_LOW) begin
			tone_code <= `TONE_NONE;
		end else if (tone_code != `TONE_NONE) begin
			if (ctrl[`CTRL_THREE_PER_BIT]) begin
				if (half_done && hold_halves == `HOLD_HALF_PERIODS) tone_code <= `TONE_NONE;
				else if (half_done) hold_halves <= hold_halves + 3'h1;
			end else if (hold_ms >= hold_len) begin
				tone_code <= `TONE_NONE;
			end else begin
				hold_ms <= hold_ms + {13'h0, ms_tick};
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			half_ms    <= 14'h0;
			tone_level <= 1'b0;
		end else if (tone_code == `TONE_NONE || tone_code == `TONE_LOW) begin
			half_ms    <= 14'h0;
			tone_level <= 1'b0;
		end else if (half_done) begin
			half_ms    <= 14'h0;
			tone_level <= !tone_level;
		end else begin
			half_ms <= half_ms + {13'h0, ms_tick};
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			DUTY                  <= 10'h0;
			FET_OFF               <= 1'b1;
			BOOST_MUTE            <= 1'b0;
			ROTATION_PULSE_OUTPUT <= 1'b0;
		end else begin
			DUTY       <= duty;
			FET_OFF    <= active != 7'h0;
			BOOST_MUTE <= active[0] || (active[4] && ctrl[`CTRL_OV_MUTE_BIT]);
			if (tone_code == `TONE_LOW) ROTATION_PULSE_OUTPUT <= 1'b0;
			else if (tone_code != `TONE_NONE) ROTATION_PULSE_OUTPUT <= tone_level;
			else ROTATION_PULSE_OUTPUT <= !mask_on && INT_PULSE;
		end
	end
endmodule : motor_speed_loop
`default_nettype wire

// ==== verification/motor_bridge_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module motor_bridge_model #(
	parameter int HALF = 40
) (
	input  wire logic SYS_CLK,
	input  wire logic ARST_N,
	input  wire logic FET_OFF,
	output var  logic INT_PULSE,
	output var  logic BEMF_EDGE
);
	int cnt;
	// With the bridge forced off the rotor is taken as stopped at once, so no pulse or edge
	// arrives; a coasting rotor would be kinder to the lock timer than the real motor.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cnt <= 0;
			INT_PULSE <= 1'b0;
			BEMF_EDGE <= 1'b0;
		end else begin
			cnt <= (FET_OFF || cnt == HALF - 1) ? 0 : cnt + 1;
			BEMF_EDGE <= !FET_OFF && cnt == HALF - 1;
			if (!FET_OFF && cnt == HALF - 1) begin
				INT_PULSE <= !INT_PULSE;
			end
		end
	end
endmodule : motor_bridge_model
`default_nettype wire

// ==== verification/motor_speed_loop_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module motor_speed_checker #(
	parameter int MS_TICK_CYC   = 4,
	parameter int RAMP_UNIT_CYC = 3
) (
	input wire logic        SYS_CLK,
	input wire logic        ARST_N,
	input wire logic        AWVALID,
	input wire logic        AWREADY,
	input wire logic        WVALID,
	input wire logic        WREADY,
	input wire logic [1:0]  BRESP,
	input wire logic        BVALID,
	input wire logic        BREADY,
	input wire logic        ARVALID,
	input wire logic        ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic        RVALID,
	input wire logic        RREADY,
	input wire logic        STARTUP_SYNC,
	input wire logic        SUPPLY_UNDERVOLTAGE,
	input wire logic        OVERCURRENT_SENSE_INPUT,
	input wire logic [9:0]  DUTY,
	input wire logic        FET_OFF,
	input wire logic        ROTATION_PULSE_OUTPUT
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	resp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("Write response changed before it was taken.");
	read_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("Read data changed before it was taken.");
	read_answer_a: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
		else $error("Read was not answered on the next cycle.");
	write_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY
		|=> !AWREADY ##[0:1] BVALID)
		else $error("Write was not answered in time.");
	uv_fet_off_a: assert property (SUPPLY_UNDERVOLTAGE [*5] |-> FET_OFF)
		else $error("Bridge left on under supply undervoltage.");
	oc_hold_a: assert property (OVERCURRENT_SENSE_INPUT [*5] |-> FET_OFF)
		else $error("Bridge on while overcurrent sense is high.");
	fault_duty_a: assert property (FET_OFF [*3] |-> DUTY == 10'h0)
		else $error("Duty not cleared during protection.");
	startup_mask_a: assert property (STARTUP_SYNC [*3] |-> !ROTATION_PULSE_OUTPUT)
		else $error("Rotation pulse seen during startup.");
endmodule : motor_speed_checker
bind motor_speed_loop motor_speed_checker #(.MS_TICK_CYC(MS_TICK_CYC),
	.RAMP_UNIT_CYC(RAMP_UNIT_CYC)) checker_i (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
	.AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
	.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
	.STARTUP_SYNC(STARTUP_SYNC), .SUPPLY_UNDERVOLTAGE(SUPPLY_UNDERVOLTAGE),
	.OVERCURRENT_SENSE_INPUT(OVERCURRENT_SENSE_INPUT), .DUTY(DUTY), .FET_OFF(FET_OFF),
	.ROTATION_PULSE_OUTPUT(ROTATION_PULSE_OUTPUT));
`default_nettype wire

// ==== verification/motor_speed_loop_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module motor_speed_loop_tb_top;
	import motor_speed_pkg::*;
	logic SYS_CLK = 1'b0;
	logic ARST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, MEAS_VALID, meas_on;
	logic STARTUP_SYNC, BEMF_DETECT, BEMF_STABLE, SUDDEN_ACCEL, OVERSPEED_DETECT;
	logic SPEED_COMMAND_BAD, SPEED_COMMAND_CYCLE, AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic FET_OFF, BOOST_MUTE, ROTATION_PULSE_OUTPUT, INT_PULSE, BEMF_EDGE;
	logic [3:0] AWADDR, ARADDR, WSTRB, mcnt;
	logic [1:0] BRESP, RRESP, resp;
	logic [31:0] WDATA, RDATA, v;
	logic [15:0] MEAS_HALF_PERIOD, TARGET_HALF_PERIOD;
	logic [9:0] DUTY, d1;
	logic [4:0] lv;
	logic [2:0] c;
	logic [15:0] cfg [3] = '{16'hff00, 16'hff01, 16'h0010};
	logic [15:0] mp [3] = '{16'h07d0, 16'h07d0, 16'h01f4};
	int steps [3] = '{20, 10, 20};
	int fail_count = 0;
	int check_count = 0;
	int n, k;
	wire logic SUPPLY_UNDERVOLTAGE = lv[0];
	wire logic BOOST_UNDERVOLTAGE = lv[1];
	wire logic OVERCURRENT_SENSE_INPUT = lv[2];
	wire logic THERMAL_HOT = lv[3];
	wire logic OVERVOLTAGE = lv[4];
	wire logic DRIVE_ON = 1'b0;
	wire logic UNDERSPEED_DETECT = 1'b0;
	always #20 SYS_CLK = ~SYS_CLK;
	motor_speed_loop #(.MS_TICK_CYC(4), .RAMP_UNIT_CYC(3)) dut (.*);
	motor_bridge_model bridge (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .FET_OFF(FET_OFF),
		.INT_PULSE(INT_PULSE), .BEMF_EDGE(BEMF_EDGE));
	// Measurements are spaced 16 cycles, safely beyond the divider's busy time.
	always @(posedge SYS_CLK) begin
		mcnt <= mcnt + 4'h1;
		MEAS_VALID <= meas_on && (mcnt == 4'h0);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test();
		if (fail_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test
	task automatic bound(input int i, input int lim);
		if (i >= lim) begin
			fail_count++;
			stop_test();
		end
	endtask : bound
	task automatic cyc(input int m);
		repeat (m) @(posedge SYS_CLK);
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		int i;
		logic done;
		@(posedge SYS_CLK);
		AWADDR <= a;
		WDATA <= d;
		WSTRB <= s;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		done = 1'b0;
		for (i = 0; i < 50 && !done; i++) begin
			@(posedge SYS_CLK);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
			if (BVALID) begin
				resp = BRESP;
				BREADY <= 1'b0;
				done = 1'b1;
			end
		end
		bound(i, 50);
	endtask : wr
	task automatic rd(input logic [3:0] a);
		int i;
		logic done;
		@(posedge SYS_CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		done = 1'b0;
		for (i = 0; i < 50 && !done; i++) begin
			@(posedge SYS_CLK);
			if (ARREADY) ARVALID <= 1'b0;
			if (RVALID) begin
				v = RDATA;
				RREADY <= 1'b0;
				done = 1'b1;
			end
		end
		bound(i, 50);
	endtask : rd
	task automatic wait_fet(input int lim);
		for (n = 0; n < lim && FET_OFF !== 1'b0; n++) @(posedge SYS_CLK);
		bound(n, lim);
	endtask : wait_fet
	task automatic wait_chg(ref logic s, input int lim);
		logic o;
		o = s;
		for (n = 0; n < lim && s === o; n++) @(posedge SYS_CLK);
		bound(n, lim);
	endtask : wait_chg
	task automatic det(input int m);
		repeat (m) begin
			BEMF_DETECT <= 1'b1;
			cyc(1);
			BEMF_DETECT <= 1'b0;
			cyc(3);
		end
	endtask : det
	initial begin
		{AWVALID, WVALID, BREADY, ARVALID, RREADY, meas_on, STARTUP_SYNC} = '0;
		{BEMF_DETECT, SUDDEN_ACCEL, OVERSPEED_DETECT, SPEED_COMMAND_BAD} = '0;
		{AWADDR, ARADDR, WSTRB, mcnt, lv, WDATA, SPEED_COMMAND_CYCLE, ARST_N} = '0;
		BEMF_STABLE = 1'b1;
		MEAS_HALF_PERIOD = 16'h07d0;
		TARGET_HALF_PERIOD = 16'h03e8;
		cyc(6);
		ARST_N <= 1'b1;
		rd(4'h0);
		chk(v, 32'h00041010);
		rd(4'h4);
		chk(v, 32'h000318ff);
		rd(4'h8);
		chk(v, 32'h00000021);
		wr(4'h0, 32'h003f0102, 4'h1);
		rd(4'h0);
		chk(v, 32'h00041002);
		wr(4'hc, 32'hffffffff, 4'hf);
		chk(resp, 2'h2);
		meas_on <= 1'b1;
		for (k = 0; k < 3; k++) begin
			wr(4'h0, {16'h0004, cfg[k]}, 4'hf);
			MEAS_HALF_PERIOD <= mp[k];
			cyc(40);
			d1 = DUTY;
			cyc(60);
			n = (k == 2) ? d1 - DUTY : DUTY - d1;
			chk(32'(n >= steps[k] - 1 && n <= steps[k] + 1), 32'h1);
		end
		MEAS_HALF_PERIOD <= 16'h03f2;
		wr(4'h0, 32'h00020000, 4'hf);
		cyc(40);
		rd(4'hc);
		chk(v[10], 1'b0);
		wr(4'h0, 32'h00030000, 4'hf);
		cyc(40);
		rd(4'hc);
		chk(v[10], 1'b1);
		meas_on <= 1'b0;
		for (k = 0; k < 2; k++) begin
			wr(4'h8, 32'h00000021 | (k << 1), 4'hf);
			STARTUP_SYNC <= 1'b1;
			cyc(5);
			STARTUP_SYNC <= 1'b0;
			det(3);
			SUDDEN_ACCEL <= 1'b1;
			cyc(1);
			SUDDEN_ACCEL <= 1'b0;
			det(4 * k + 5);
			rd(4'hc);
			chk(v[11], 1'b1);
			chk(ROTATION_PULSE_OUTPUT, 1'b0);
			det(1);
			rd(4'hc);
			chk(v[11], 1'b0);
		end
		wait_chg(INT_PULSE, 100);
		cyc(3);
		chk(ROTATION_PULSE_OUTPUT, INT_PULSE);
		wr(4'h8, 32'h00000065, 4'hf);
		for (k = 2; k < 4; k++) begin
			lv[k] <= 1'b1;
			cyc(8);
			rd(4'hc);
			chk(v[21:12], {3'(k - 1), 7'(1 << k)});
			if (k == 2) begin
				wait_chg(ROTATION_PULSE_OUTPUT, 2100);
				wait_chg(ROTATION_PULSE_OUTPUT, 2100);
				chk(32'(n > 1997 && n < 2003), 32'h1);
				cyc(18100);
				chk(FET_OFF, 1'b1);
			end
			lv[k] <= 1'b0;
			wait_fet(20100);
			chk(32'(k == 2 ? n < 20 : n > 19900), 32'h1);
			if (k == 2) begin
				cyc(4000);
				rd(4'hc);
				chk(v[21:19], 3'h1);
				cyc(8500);
				rd(4'hc);
				chk(v[21:19], 3'h0);
			end
		end
		rd(4'hc);
		c = v[21:19];
		lv[1] <= 1'b1;
		lv[4] <= 1'b1;
		cyc(8);
		rd(4'hc);
		chk(v[21:19], c);
		chk(BOOST_MUTE, 1'b1);
		lv[1] <= 1'b0;
		cyc(8);
		rd(4'hc);
		chk(v[21:12], {3'h3, 7'h10});
		lv[0] <= 1'b1;
		cyc(8);
		rd(4'hc);
		chk(v[21:19], 3'h7);
		chk(ROTATION_PULSE_OUTPUT, 1'b0);
		lv[0] <= 1'b0;
		cyc(8);
		chk(BOOST_MUTE, 1'b1);
		lv[4] <= 1'b0;
		wait_fet(20100);
		cyc(2);
		chk(BOOST_MUTE, 1'b0);
		SPEED_COMMAND_BAD <= 1'b1;
		cyc(585);
		rd(4'hc);
		chk(v[18], 1'b0);
		cyc(20);
		rd(4'hc);
		chk(v[21:18], 4'hb);
		SPEED_COMMAND_BAD <= 1'b0;
		for (k = 0; k < 15; k++) begin
			rd(4'hc);
			chk(v[18], 1'b1);
			SPEED_COMMAND_CYCLE <= 1'b1;
			cyc(1);
			SPEED_COMMAND_CYCLE <= 1'b0;
		end
		cyc(2);
		rd(4'hc);
		chk(v[18], 1'b0);
		OVERSPEED_DETECT <= 1'b1;
		cyc(1);
		OVERSPEED_DETECT <= 1'b0;
		cyc(6);
		chk(FET_OFF, 1'b1);
		rd(4'hc);
		chk(v[17], 1'b1);
		stop_test();
	end
endmodule : motor_speed_loop_tb_top
`default_nettype wire
